// *** mitp_pin_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface mitp_pin_if;
   logic sclk_lvl;
   logic lrck_lvl;
   modport src (output sclk_lvl, output lrck_lvl);
   modport dst (input sclk_lvl, input lrck_lvl);
endinterface
`default_nettype wire

// *** mitp_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module mitp_pin_sync (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Raw clock pins from the far side
   input wire logic sclk_in,
   input wire logic lrck_in,
   // Synchronised levels
   mitp_pin_if.src pins
);
   logic [1:0] sclk_sh;
   logic [1:0] lrck_sh;
   logic [1:0] next_sclk_sh;
   logic [1:0] next_lrck_sh;

   // Two-stage shift; only stage one feeds stage two
   always_comb begin
      next_sclk_sh = {sclk_sh[0], sclk_in};
      next_lrck_sh = {lrck_sh[0], lrck_in};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_sh <= 2'h0;
         lrck_sh <= 2'h0;
      end else begin
         sclk_sh <= next_sclk_sh;
         lrck_sh <= next_lrck_sh;
      end
   end

   assign pins.sclk_lvl = sclk_sh[1];
   assign pins.lrck_lvl = lrck_sh[1];
endmodule // mitp_pin_sync
`default_nettype wire

// *** mitp_pkg.sv ***
package mitp_pkg;
   // Register byte offsets
   localparam logic [7:0] MITP_CTRL_OFS = 8'h00;
   localparam logic [7:0] MITP_STATUS_OFS = 8'h04;
   // Control register bit positions
   localparam int MITP_MS_BIT = 0;
   localparam int MITP_RATIO_BIT = 1;
   localparam int MITP_TRI_BIT = 2;
   localparam int MITP_PDN_BIT = 3;
   localparam logic [3:0] MITP_CTRL_RST = 4'h0;
   // Status register bit positions
   localparam int MITP_ST_SYNC_ERR = 0;
   localparam int MITP_ST_SHORT = 1;
   localparam int MITP_ST_SUPPLY_UNDERVOLTAGE_FLAG = 2;
   localparam int MITP_ST_CURLIM = 3;
   localparam int MITP_ST_BOOST_OV = 4;
   localparam int MITP_ST_OTW = 5;
   localparam int MITP_ST_OTE = 6;
   localparam int MITP_ST_SPK_OVFL = 7;
   localparam int MITP_ST_BATT_OVFL = 8;
   localparam int MITP_ST_POWERDOWN_COMPLETE = 9;
   localparam int MITP_ST_FLASH = 10;
   localparam int MITP_ST_VALID = 11;
   localparam int MITP_ST_LOCKED = 12;
   // Master clock ticks per frame clock period
   localparam logic [7:0] MITP_RATIO_125 = 8'h7d;
   localparam logic [7:0] MITP_RATIO_128 = 8'h80;
   // Frame clock checker window, in master clock ticks
   localparam logic [7:0] MITP_SYNC_TOL = 8'h02;
   // Channel word layout
   localparam int MITP_WORD_BITS = 32;
   localparam logic [7:0] MITP_EXT_RSVD = 8'h00;
   // Half periods seen after re-enable before data counts as valid
   localparam logic [1:0] MITP_WARM_HALVES = 2'h2;
   typedef enum logic {MITP_CK_HUNT, MITP_CK_LOCK} mitp_ck_state_t;
endpackage

// *** mitp_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mitp_rx_model (
   // Bench controls
   input wire logic run,
   input wire logic [5:0] bits,
   // Data pin as seen on the board
   input wire logic sd,
   // Clocks made in slave mode
   output logic sclk,
   output logic lrck,
   // Last whole words
   output logic [31:0] word_l,
   output logic [31:0] word_r,
   output int frames
);
   logic [31:0] w [2];
   int chp;
   int bp;
   // Clock rests low between frames; a stop lands only at a frame end
   initial begin
      sclk = 1'b0;
      lrck = 1'b1;
      frames = 0;
      chp = 0;
      bp = -1;
      forever begin
         wait (run === 1'b1);
         for (int ch = 0; ch < 2; ch++) begin
            for (int b = 0; b < int'(bits); b++) begin
               sclk = 1'b1;
               #100;
               // Sample before our fall: the port answers late
               if (bp == 0) begin
                  w[1-chp] = {w[1-chp][30:0], sd};
                  if (chp == 1) word_l = w[0];
                  else word_r = w[1];
                  if (chp == 0) frames++;
               end else if (bp == 1) w[chp] = {31'h0, sd};
               else if (bp > 1) w[chp] = {w[chp][30:0], sd};
               sclk = 1'b0;
               if (b == 0) lrck = ch[0];
               chp = ch;
               bp = b;
               #100;
            end
         end
      end
   end
endmodule // mitp_rx_model
`default_nettype wire

// *** mitp_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Master bit makes clock pins outputs, else inputs
// - Master derives clocks, about 64 bit clocks
// - Ratio field: 1 means 125, 0 means 128
// - Missing frame edge sets sync error flag
// - Integer-multiple frame rate is not flagged
// - Stopped frame clock flags only once
// - Transmit only, monitor data in I2S framing
// - Short frames truncate after available clocks
// - Bits after 24th are zero when reserved
// - Up to 32 bits per channel word
// - Frame clock transition starts each channel
// - Data changes on bit clock fall, MSB first
// - Short flag reported, forces speaker-safe state
// - Undervoltage flag reported while shut down
// - Boost current-limit flag reported live
// - Boost overvoltage flag reported
// - Overtemperature warning flag reported live
// - Overtemperature error flag, forces speaker-safe
// - Tristate floats data pin, clock pins unchanged
// - Data valid one frame period after re-enable
// - Left voltage+battery, right current+status bits
// - Monitor overflow flags reported
module mitp_top #(
   parameter logic [7:0] SYNC_TOL = mitp_pkg::MITP_SYNC_TOL
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Internal master clock, one-cycle enable per tick
   input wire logic mclk_en,
   // Bit clock pin
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   // Frame clock pin
   input wire logic lrck_in,
   output logic lrck_out,
   output logic lrck_oe,
   // Serial data pin
   output logic serial_data_out,
   output logic serial_data_oe,
   // Monitor samples from the core
   input wire logic [15:0] speaker_voltage_sample,
   input wire logic [15:0] speaker_current_sample,
   input wire logic [7:0] battery_voltage_sample,
   // Status flags from the core
   input wire logic speaker_short_flag,
   input wire logic supply_undervoltage_flag,
   input wire logic boost_current_limit_flag,
   input wire logic boost_overvoltage_flag,
   input wire logic overtemp_warning_flag,
   input wire logic overtemp_error_flag,
   input wire logic speaker_monitor_overflow,
   input wire logic battery_monitor_overflow,
   input wire logic powerdown_complete,
   input wire logic flash_timer_active,
   // Controls back to the core
   output logic amplifier_powerdown,
   output logic speaker_safe
);
   import mitp_pkg::*;

   if (SYNC_TOL < 8'h01 || SYNC_TOL > 8'h10) begin : g_tol_check
      $error("SYNC_TOL must lie between 1 and 16");
   end

   // Control register fields
   logic [3:0] ctrl;
   logic [3:0] next_ctrl;
   logic master;
   logic ratio_sel;
   logic tristate;

   // Bus answer state
   logic next_pready;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic frame_clock_sync_error;
   logic next_sync_error;

   // Clock generation and checker timeline
   logic [7:0] phase;
   logic [7:0] next_phase;
   logic next_sclk_out;
   logic next_lrck_out;
   logic [7:0] ratio;
   logic [7:0] half;
   mitp_ck_state_t ck_state;
   mitp_ck_state_t next_ck_state;
   logic seen;
   logic next_seen;
   logic sync_err_evt;
   logic in_window;

   // Edge tracking on the selected clocks
   logic sclk_lvl;
   logic lrck_lvl;
   logic sclk_d;
   logic lrck_d;
   logic sclk_fall;
   logic lrck_rise;

   // Shifter state
   logic lrck_last;
   logic next_lrck_last;
   logic [MITP_WORD_BITS-1:0] shreg;
   logic [MITP_WORD_BITS-1:0] next_shreg;
   logic [MITP_WORD_BITS-1:0] right_hold;
   logic [MITP_WORD_BITS-1:0] next_right_hold;
   logic [MITP_WORD_BITS-1:0] left_word;
   logic [MITP_WORD_BITS-1:0] right_word;
   logic [1:0] warm;
   logic [1:0] next_warm;
   logic data_valid;
   logic next_sdo;
   logic next_speaker_safe;

   // Bus access phases; writes land where the master sees pready
   logic acc_first;
   logic acc_done;
   logic addr_ok;

   mitp_pin_if pins ();

   mitp_pin_sync u_pin_sync (
      .pclk (pclk),
      .presetn (presetn),
      .sclk_in (sclk_in),
      .lrck_in (lrck_in),
      .pins (pins)
   );

   assign master = ctrl[MITP_MS_BIT];
   assign ratio_sel = ctrl[MITP_RATIO_BIT];
   assign tristate = ctrl[MITP_TRI_BIT];
   assign acc_first = psel & penable & ~pready;
   assign acc_done = psel & penable & pready;
   assign addr_ok = (paddr == MITP_CTRL_OFS) || (paddr == MITP_STATUS_OFS);

   // Ratio field picks the frame length in master ticks
   assign ratio = ratio_sel ? MITP_RATIO_125 : MITP_RATIO_128;
   assign half = {1'b0, ratio[7:1]};

   // Master uses its own clocks, slave the synchronised pins
   assign sclk_lvl = master ? sclk_out : pins.sclk_lvl;
   assign lrck_lvl = master ? lrck_out : pins.lrck_lvl;
   assign sclk_fall = sclk_d & ~sclk_lvl;
   assign lrck_rise = lrck_lvl & ~lrck_d;
   assign in_window = (phase <= SYNC_TOL) || (phase >= ratio - SYNC_TOL);
   assign data_valid = (warm == MITP_WARM_HALVES);

   // Left: voltage then battery; right: current then status
   assign left_word = {speaker_voltage_sample, battery_voltage_sample,
                       MITP_EXT_RSVD};
   assign right_word = {speaker_current_sample, speaker_short_flag,
                        overtemp_warning_flag, overtemp_error_flag,
                        speaker_monitor_overflow,
                        battery_monitor_overflow, powerdown_complete,
                        boost_current_limit_flag, flash_timer_active,
                        MITP_EXT_RSVD};

   // Register writes and answers; hardware set beats software clear
   always_comb begin
      next_ctrl = ctrl;
      next_pready = acc_first;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      next_sync_error = frame_clock_sync_error | sync_err_evt;
      if (acc_first) begin
         next_pslverr = ~addr_ok;
         next_prdata = 32'h0000_0000;
         if (!pwrite && paddr == MITP_CTRL_OFS) begin
            next_prdata[3:0] = ctrl;
         end else if (!pwrite && paddr == MITP_STATUS_OFS) begin
            next_prdata[MITP_ST_SYNC_ERR] = frame_clock_sync_error;
            next_prdata[MITP_ST_SHORT] = speaker_short_flag;
            next_prdata[MITP_ST_SUPPLY_UNDERVOLTAGE_FLAG] = supply_undervoltage_flag;
            next_prdata[MITP_ST_CURLIM] = boost_current_limit_flag;
            next_prdata[MITP_ST_BOOST_OV] = boost_overvoltage_flag;
            next_prdata[MITP_ST_OTW] = overtemp_warning_flag;
            next_prdata[MITP_ST_OTE] = overtemp_error_flag;
            next_prdata[MITP_ST_SPK_OVFL] = speaker_monitor_overflow;
            next_prdata[MITP_ST_BATT_OVFL] = battery_monitor_overflow;
            next_prdata[MITP_ST_POWERDOWN_COMPLETE] = powerdown_complete;
            next_prdata[MITP_ST_FLASH] = flash_timer_active;
            next_prdata[MITP_ST_VALID] = data_valid;
            next_prdata[MITP_ST_LOCKED] = (ck_state == MITP_CK_LOCK);
         end
      end
      if (acc_done && pwrite && paddr == MITP_CTRL_OFS) begin
         next_ctrl = pwdata[3:0];
      end
      if (acc_done && pwrite && paddr == MITP_STATUS_OFS &&
          pwdata[MITP_ST_SYNC_ERR] && !sync_err_evt) begin
         next_sync_error = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= MITP_CTRL_RST;
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         frame_clock_sync_error <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         frame_clock_sync_error <= next_sync_error;
      end
   end

   // One timeline: drives the clocks as master, checks them as slave
   always_comb begin
      next_phase = phase;
      next_sclk_out = sclk_out;
      next_lrck_out = lrck_out;
      next_ck_state = ck_state;
      next_seen = seen;
      sync_err_evt = 1'b0;
      if (master) begin
         next_ck_state = MITP_CK_HUNT;
         next_seen = 1'b0;
         if (mclk_en) begin
            // Bit clock toggles per tick, so 128 ticks give 64 clocks
            // A ratio change mid-frame must not run phase past the wrap
            if (phase >= ratio - 8'h01) begin
               next_phase = 8'h00;
               next_lrck_out = 1'b0;
               next_sclk_out = 1'b0;
            end else begin
               next_phase = phase + 8'h01;
               if (phase + 8'h01 == half) begin
                  next_lrck_out = 1'b1;
                  next_sclk_out = 1'b0;
               end else begin
                  next_sclk_out = ~sclk_out;
               end
            end
         end
      end else begin
         // Pins released; the far side must run at the core rate
         next_sclk_out = 1'b0;
         next_lrck_out = 1'b0;
         case (ck_state)
            MITP_CK_HUNT: begin
               // No repeat flag while the frame clock is gone
               if (lrck_rise) begin
                  next_phase = 8'h00;
                  next_seen = 1'b1;
                  next_ck_state = MITP_CK_LOCK;
               end
            end
            MITP_CK_LOCK: begin
               // Off-window edges are ignored, so double rate passes
               if (lrck_rise && in_window) begin
                  next_phase = 8'h00;
                  next_seen = 1'b1;
               end else if (mclk_en) begin
                  if (phase >= ratio - 8'h01) begin
                     next_phase = 8'h00;
                  end else begin
                     next_phase = phase + 8'h01;
                  end
                  if (phase == SYNC_TOL) begin
                     if (!seen) begin
                        sync_err_evt = 1'b1;
                        next_ck_state = MITP_CK_HUNT;
                     end
                     next_seen = 1'b0;
                  end
               end
            end
            default: begin
               next_ck_state = MITP_CK_HUNT;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 8'h00;
         sclk_out <= 1'b0;
         lrck_out <= 1'b0;
         ck_state <= MITP_CK_HUNT;
         seen <= 1'b0;
         sclk_d <= 1'b0;
         lrck_d <= 1'b0;
      end else begin
         phase <= next_phase;
         sclk_out <= next_sclk_out;
         lrck_out <= next_lrck_out;
         ck_state <= next_ck_state;
         seen <= next_seen;
         sclk_d <= sclk_lvl;
         lrck_d <= lrck_lvl;
      end
   end

   // Shifter works only on bit clock falls; input is never read
   always_comb begin
      next_lrck_last = lrck_last;
      next_shreg = shreg;
      next_right_hold = right_hold;
      next_warm = warm;
      next_sdo = serial_data_out;
      if (tristate) begin
         next_warm = 2'h0;
         next_sdo = 1'b0;
         // Keep tracking the frame clock so no stale edge counts later
         if (sclk_fall) begin
            next_lrck_last = lrck_lvl;
         end
      end else if (sclk_fall) begin
         // Every fall moves one bit; zeros fill, short frames stop early
         next_sdo = data_valid & shreg[MITP_WORD_BITS-1];
         next_shreg = {shreg[MITP_WORD_BITS-2:0], 1'b0};
         if (lrck_lvl != lrck_last) begin
            // New channel; this slot still carries the old last bit
            next_lrck_last = lrck_lvl;
            if (!lrck_lvl) begin
               // Right word captured with left, so pairs match
               next_shreg = left_word;
               next_right_hold = right_word;
            end else begin
               next_shreg = right_hold;
            end
            if (!data_valid) begin
               next_warm = warm + 2'h1;
            end
         end
      end
   end

   // Safe-state request follows the short and damage flags
   assign next_speaker_safe = speaker_short_flag | overtemp_error_flag;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lrck_last <= 1'b0;
         shreg <= '0;
         right_hold <= '0;
         warm <= 2'h0;
         serial_data_out <= 1'b0;
         serial_data_oe <= 1'b0;
         sclk_oe <= 1'b0;
         lrck_oe <= 1'b0;
         amplifier_powerdown <= 1'b0;
         speaker_safe <= 1'b0;
      end else begin
         lrck_last <= next_lrck_last;
         shreg <= next_shreg;
         right_hold <= next_right_hold;
         warm <= next_warm;
         serial_data_out <= next_sdo;
         serial_data_oe <= ~tristate;
         sclk_oe <= master;
         lrck_oe <= master;
         amplifier_powerdown <= ctrl[MITP_PDN_BIT];
         speaker_safe <= next_speaker_safe;
      end
   end
endmodule // mitp_top
`default_nettype wire

// *** mitp_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module mitp_top_chk #(
   parameter logic [7:0] SYNC_TOL = mitp_pkg::MITP_SYNC_TOL
) (
   // Clock and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic mclk_en,
   input wire logic sclk_out,
   input wire logic sclk_oe,
   input wire logic lrck_out,
   input wire logic lrck_oe,
   input wire logic serial_data_out,
   input wire logic serial_data_oe,
   // Core side
   input wire logic speaker_short_flag,
   input wire logic overtemp_error_flag,
   input wire logic amplifier_powerdown,
   input wire logic speaker_safe
);
   import mitp_pkg::*;
   logic ctrl_wr;
   logic held_tri;
   logic held_pdn;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed write to the control word
   assign ctrl_wr = psel && penable && pready && pwrite && paddr == MITP_CTRL_OFS;
   // What software last asked for, to judge the outputs against
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_tri <= 1'b0;
         held_pdn <= 1'b0;
      end else if (ctrl_wr) begin
         held_tri <= pwdata[MITP_TRI_BIT];
         held_pdn <= pwdata[MITP_PDN_BIT];
      end
   end
   AST_ACCESS_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_SLAVE_PINS: assert property (!sclk_oe |-> !sclk_out && !lrck_out && !lrck_oe)
      else $error("clock pins driven in slave mode");
   AST_TRI_PIN: assert property (!serial_data_oe |-> !serial_data_out)
      else $error("data active while floated");
   AST_TRI_FOLLOWS: assert property (ctrl_wr |-> ##[1:2] serial_data_oe == !held_tri)
      else $error("data enable ignores control");
   AST_PDN_FOLLOWS: assert property (ctrl_wr |-> ##[1:2] amplifier_powerdown == held_pdn)
      else $error("powerdown ignores control");
   AST_SAFE_SET: assert property (speaker_short_flag || overtemp_error_flag |=> speaker_safe)
      else $error("safe state not entered");
   AST_SAFE_CLR: assert property (!speaker_short_flag && !overtemp_error_flag |=> !speaker_safe)
      else $error("safe state without cause");
   AST_SCLK_ON_TICK: assert property (sclk_oe && $past(sclk_oe) && $changed(sclk_out) |-> $past(mclk_en))
      else $error("bit clock moved without tick");
   AST_LRCK_SCLK_LOW: assert property (lrck_oe && $past(lrck_oe) && $changed(lrck_out) |-> !sclk_out)
      else $error("frame clock moved with bit clock high");
endmodule // mitp_top_chk
bind mitp_top mitp_top_chk #(.SYNC_TOL(SYNC_TOL)) chk_u (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .mclk_en(mclk_en), .sclk_out(sclk_out),
   .sclk_oe(sclk_oe), .lrck_out(lrck_out), .lrck_oe(lrck_oe),
   .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
   .speaker_short_flag(speaker_short_flag),
   .overtemp_error_flag(overtemp_error_flag),
   .amplifier_powerdown(amplifier_powerdown), .speaker_safe(speaker_safe)
);
`default_nettype wire

// *** tb_monitor_i2s_transmit_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_i2s_transmit_port;
   import mitp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic pready, pslverr, mclk_en = 1'b0, run = 1'b0;
   logic [31:0] prdata, word_l, word_r;
   logic [1:0] div = 2'h0;
   logic sclk_out, sclk_oe, lrck_out, lrck_oe, sd_out, sd_oe, pdn, safe;
   logic m_sclk, m_lrck;
   logic [5:0] bits = 6'h20;
   logic [15:0] vs = 16'ha5c3;
   logic [15:0] is = 16'h3c5a;
   logic [7:0] bs = 8'h96;
   logic [9:0] flg = 10'h12f;
   int frames, failures = 0, n_compared = 0;
   // Released data line is pulled high on the board
   wire logic sd_pin = sd_oe ? sd_out : 1'b1;
   wire logic sclk_pin = sclk_oe ? sclk_out : m_sclk;
   wire logic lrck_pin = lrck_oe ? lrck_out : m_lrck;
   always #12.5 pclk = ~pclk;
   // Internal master clock: one tick every 100 ns
   always @(posedge pclk) begin
      div <= div + 2'h1;
      mclk_en <= (div == 2'h3);
   end
   mitp_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .mclk_en(mclk_en), .sclk_in(sclk_pin), .sclk_out(sclk_out),
      .sclk_oe(sclk_oe), .lrck_in(lrck_pin), .lrck_out(lrck_out),
      .lrck_oe(lrck_oe), .serial_data_out(sd_out), .serial_data_oe(sd_oe),
      .speaker_voltage_sample(vs), .speaker_current_sample(is),
      .battery_voltage_sample(bs), .speaker_short_flag(flg[0]),
      .supply_undervoltage_flag(flg[1]), .boost_current_limit_flag(flg[2]),
      .boost_overvoltage_flag(flg[3]), .overtemp_warning_flag(flg[4]),
      .overtemp_error_flag(flg[5]), .speaker_monitor_overflow(flg[6]),
      .battery_monitor_overflow(flg[7]), .powerdown_complete(flg[8]),
      .flash_timer_active(flg[9]), .amplifier_powerdown(pdn),
      .speaker_safe(safe));
   mitp_rx_model model_u (.run(run), .bits(bits), .sd(sd_pin),
      .sclk(m_sclk), .lrck(m_lrck), .word_l(word_l), .word_r(word_r),
      .frames(frames));
   task tally_and_finish;
      if (failures == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One bus transfer; request held until pready is seen
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) failures++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
               input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & m, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // Expected channel word, cut to the clocks on offer
   function automatic logic [31:0] exp_word(input logic ch, input int n);
      logic [31:0] full;
      full = ch ? {is, flg[0], flg[4], flg[5], flg[6], flg[7], flg[8], flg[2],
                   flg[9], 8'h00} : {vs, bs, 8'h00};
      return full >> (32 - n);
   endfunction
   task wait_frames(input int k);
      int f0;
      f0 = frames;
      repeat (9000) if (frames < f0 + k) @(posedge pclk);
      if (frames < f0 + k) failures++;
   endtask
   task t_regs;
      rd_chk(MITP_CTRL_OFS, 32'hffffffff, 32'h0, 1'b0);
      rd_chk(8'h08, 32'hffffffff, 32'h0, 1'b1);
      rd_chk(MITP_STATUS_OFS, 32'h7fe, 32'({flg, 1'b0}), 1'b0);
      chk(32'(safe), 32'h1);
      flg <= 10'h2d0;
      rd_chk(MITP_STATUS_OFS, 32'h7fe, 32'h5a0, 1'b0);
      chk(32'(safe), 32'h0);
      flg <= 10'h12f;
      wr(MITP_CTRL_OFS, 32'h2);
      rd_chk(MITP_CTRL_OFS, 32'hffffffff, 32'h2, 1'b0);
      wr(MITP_CTRL_OFS, 32'h0);
   endtask
   task t_frame(input int n);
      bits <= n[5:0];
      wait_frames(3);
      chk(word_l, exp_word(1'b0, n));
      chk(word_r, exp_word(1'b1, n));
   endtask
   // Float the data pin mid-stream, then bring it back
   task t_tristate;
      wr(MITP_CTRL_OFS, 32'h4);
      repeat (3) @(posedge pclk);
      chk(32'({sd_oe, sd_out, sclk_oe, lrck_oe}), 32'h0);
      wr(MITP_CTRL_OFS, 32'h0);
      rd_chk(MITP_STATUS_OFS, 32'h800, 32'h0, 1'b0);
      wait_frames(2);
      rd_chk(MITP_STATUS_OFS, 32'h800, 32'h800, 1'b0);
      chk(word_r, exp_word(1'b1, int'(bits)));
   endtask
   task t_sync;
      bits <= 6'h20;
      // Let the checker settle after the rate change before clearing
      wait_frames(4);
      wr(MITP_STATUS_OFS, 32'h1);
      wait_frames(3);
      rd_chk(MITP_STATUS_OFS, 32'h1, 32'h0, 1'b0);
      bits <= 6'h10;
      wait_frames(4);
      wr(MITP_STATUS_OFS, 32'h1);
      wait_frames(3);
      rd_chk(MITP_STATUS_OFS, 32'h1, 32'h0, 1'b0);
      run <= 1'b0;
      repeat (2000) @(posedge pclk);
      rd_chk(MITP_STATUS_OFS, 32'h1, 32'h1, 1'b0);
      wr(MITP_STATUS_OFS, 32'h1);
      repeat (2000) @(posedge pclk);
      rd_chk(MITP_STATUS_OFS, 32'h1, 32'h0, 1'b0);
   endtask
   // Single-device use only, so the 125 ratio is legal as master
   task t_master(input logic ratio);
      int lr;
      int sc;
      int tk;
      logic pl;
      logic ps;
      wr(MITP_CTRL_OFS, {30'h0, ratio, 1'b1});
      lr = 0;
      sc = 0;
      tk = 0;
      pl = lrck_out;
      ps = sclk_out;
      repeat (3000) if (lr < 3) begin
         @(posedge pclk);
         if (lr > 0 && sclk_out && !ps) sc++;
         if (lr > 0 && mclk_en) tk++;
         if (lrck_out && !pl) lr++;
         ps = sclk_out;
         pl = lrck_out;
      end
      // Halves of 64/64 or 62/63 ticks give 64 or 62 clocks a frame
      chk(sc, ratio ? 124 : 128);
      chk(tk, ratio ? 250 : 256);
      chk(32'({sclk_oe, lrck_oe}), 32'h3);
   endtask
   task t_clock_only;
      wr(MITP_CTRL_OFS, 32'hd);
      repeat (3) @(posedge pclk);
      chk(32'({pdn, sd_oe, lrck_oe}), 32'h5);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      run <= 1'b1;
      t_frame(32);
      t_frame(20);
      t_tristate();
      t_sync();
      t_master(1'b0);
      t_master(1'b1);
      t_clock_only();
      tally_and_finish();
   end
   // Watchdog well past the expected run length
   initial begin
      repeat (40000) @(posedge pclk);
      failures++;
      tally_and_finish();
   end
endmodule // tb_monitor_i2s_transmit_port
`default_nettype wire
